// ---- cie_core.sv ----
// instruction execute core with wishbone access to its state
// Functional notes
// - add literal adds 8-bit literal to accumulator, sets C, DC, Z.
// - add acc file adds accumulator and file register, sets C, DC, Z.
// - destination select 0 writes accumulator, 1 writes file register.
// - and literal ANDs accumulator with literal, updates only zero flag.
// - and acc file ANDs accumulator with file, to destination, only Z.
// - set bit forces indexed bit to one, no flags change.
// - clear bit forces indexed bit to zero, no flags change.
// - test skip set squashes next instruction when bit is one.
// - test skip clear squashes next instruction when bit is zero.
// - subroutine jump pushes counter plus one, loads 11-bit target, two cycles.
// - jumps take counter bits 12:11 from page latch bits 4:3.
// - absolute jump loads target, no stack or flag change, two cycles.
// - watchdog kick clears counter and prescaler, sets both status bits.
// - zero file writes zero to file register and sets Z.
// - zero acc writes zero to accumulator and sets Z.
// - invert file complements file to destination, updates Z.
// - decrement file subtracts one to destination, updates Z.
// - decrement skip zero changes no flag, skips on zero result.
// - increment skip zero changes no flag, skips on wrap to zero.
// - increment file adds one to destination, updates Z.
// - or literal ORs accumulator with literal, updates Z.
// - or acc file ORs accumulator with file to destination, updates Z.
// - move file copies file to destination and updates Z.
// - instruction cycle is four clocks; skips and jumps add a no-op cycle.
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
module cie_core import cie_pkg::*; #(
  parameter int FILE_DEPTH = 128
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             busy_o,
  output logic [PC_W-1:0]  pc_o
);
  // architectural state
  logic [7:0]          acc_r;
  logic [7:0]          status_r;
  logic [PC_W-1:0]     pc_r;
  logic [7:0]          page_r;
  logic [WDT_W-1:0]    wdt_r;
  logic [PRE_W-1:0]    pre_r;
  logic [PC_W-1:0]     stack_r [STACK_D];
  logic [STACK_AW-1:0] sp_r;
  logic [7:0]          file_r [FILE_DEPTH];
  logic [FADDR_W-1:0]  dbg_addr_r;
  logic [OP_W-1:0]     instr_r;
  logic                go_r;
  logic [1:0]          q_r;
  logic                flush_r;

  cie_dec_t dec;
  cie_alu_t alu;

  cie_decode u_dec (
    .instr_i (instr_r),
    .dec_o   (dec)
  );

  cie_alu u_alu (
    .dec_i  (dec),
    .acc_i  (acc_r),
    .file_i (file_r[dec.faddr]),
    .alu_o  (alu)
  );

  // bus decode; every access acks in one cycle, unmapped reads return zero
  wire logic bus_req  = cyc_i && stb_i && !ack_o;
  wire logic bus_wr   = bus_req && we_i && sel_i[0];
  wire logic wr_instr = bus_wr && (adr_i == REG_INSTR) && !busy_o;
  wire logic wr_acc   = bus_wr && (adr_i == REG_ACC) && !busy_o;
  wire logic wr_page  = bus_wr && (adr_i == REG_PAGE) && !busy_o;
  wire logic wr_faddr = bus_wr && (adr_i == REG_FADDR);
  wire logic wr_fdata = bus_wr && (adr_i == REG_FDATA) && !busy_o;

  // execution happens on the last quarter of an instruction cycle
  wire logic last_q   = go_r && (q_r == 2'(QUARTERS - 1));
  wire logic exec     = last_q && !flush_r;
  wire logic is_jump  = (dec.op == CIE_CALL) || (dec.op == CIE_JMP);
  wire logic need_nop = exec && (alu.skip || is_jump);
  wire logic to_file  = exec && ((dec.op inside {CIE_BSF, CIE_BCF, CIE_ZF})
                     || (dec.dest && (dec.op inside {CIE_ADD_ACC_FILE, CIE_AND_ACC_FILE, CIE_INV, CIE_DEC,
                         CIE_DECSZ, CIE_INC, CIE_INCSZ, CIE_ORWF, CIE_MOVE_FILE})));
  wire logic to_acc   = exec && !to_file && (dec.op inside {CIE_ADD_LITERAL_ACC, CIE_AND_LITERAL_ACC, CIE_ORLW, CIE_ZA,
                         CIE_ADD_ACC_FILE, CIE_AND_ACC_FILE, CIE_INV, CIE_DEC, CIE_DECSZ, CIE_INC,
                         CIE_INCSZ, CIE_ORWF, CIE_MOVE_FILE});
  wire logic [PC_W-1:0] pc_inc  = pc_r + 13'h0001;
  wire logic [PC_W-1:0] pc_jump = {page_r[PAGE_LSB+1:PAGE_LSB], dec.jaddr};
  // a skip steps over the squashed word, so the next fetch lands two words on
  wire logic [PC_W-1:0] pc_skip = pc_r + 13'h0002;
  wire logic [PC_W-1:0] pc_next = is_jump ? pc_jump : (alu.skip ? pc_skip : pc_inc);

  // quarter counter and busy span
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      go_r    <= 1'b0;
      q_r     <= 2'h0;
      flush_r <= 1'b0;
      instr_r <= '0;
    end else begin
      if (wr_instr) begin
        instr_r <= dat_i[OP_W-1:0];
        go_r    <= 1'b1;
        q_r     <= 2'h0;
        flush_r <= 1'b0;
      end else if (go_r) begin
        q_r <= q_r + 2'h1;
        if (last_q) begin
          go_r    <= need_nop;  // extra cycle runs as a no-op
          flush_r <= need_nop;
        end
      end
    end
  end

  // accumulator and flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_r    <= 8'h00;
      status_r <= STATUS_RST;
    end else begin
      if (wr_acc) acc_r <= dat_i[7:0];
      else if (to_acc) acc_r <= alu.res;
      if (exec && alu.upd_z) status_r[ST_Z] <= alu.z;
      if (exec && alu.upd_cdc) begin
        status_r[ST_C]  <= alu.c;
        status_r[ST_DC] <= alu.dc;
      end
      if (exec && dec.op == CIE_WDK) begin
        status_r[ST_TO] <= 1'b1;
        status_r[ST_PD] <= 1'b1;
      end
    end
  end

  // program counter, stack and page latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_r   <= '0;
      sp_r   <= '0;
      page_r <= 8'h00;
    end else begin
      if (wr_page) page_r <= dat_i[7:0];
      if (exec) begin
        pc_r <= pc_next;
        if (dec.op == CIE_CALL) begin
          stack_r[sp_r] <= pc_inc;
          sp_r          <= sp_r + 3'h1;
        end
      end
    end
  end

  // watchdog counter and prescaler free-run, cleared by the kick
  always_ff @(posedge clk_i) begin
    if (rst_i || (exec && dec.op == CIE_WDK)) begin
      wdt_r <= '0;
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
      if (&pre_r) wdt_r <= wdt_r + 1'b1;
    end
  end

  // file registers; not reset, software preloads them over the bus
  always_ff @(posedge clk_i) begin
    if (wr_fdata) file_r[dbg_addr_r] <= dat_i[7:0];
    else if (to_file) file_r[dec.faddr] <= alu.res;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) dbg_addr_r <= '0;
    else if (wr_faddr) dbg_addr_r <= dat_i[FADDR_W-1:0];
  end

  // read mux
  logic [31:0] rd;
  always_comb begin
    case (adr_i)
      REG_INSTR:  rd = {18'h0, instr_r};
      REG_ACC:    rd = {24'h0, acc_r};
      REG_STATUS: rd = {24'h0, status_r};
      REG_PC:     rd = {19'h0, pc_r};
      REG_PAGE:   rd = {24'h0, page_r};
      REG_HEAD:   rd = {19'h0, stack_r[sp_r - 3'h1]};
      REG_WDT:    rd = {24'h0, wdt_r};
      REG_FADDR:  rd = {25'h0, dbg_addr_r};
      REG_FDATA:  rd = {24'h0, file_r[dbg_addr_r]};
      default:    rd = 32'h0;
    endcase
  end

  // registered bus answer and status outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o  <= 1'b0;
      dat_o  <= '0;
      busy_o <= 1'b0;
      pc_o   <= '0;
    end else begin
      ack_o  <= bus_req;
      dat_o  <= rd;
      busy_o <= wr_instr || (go_r && !(last_q && !need_nop));
      pc_o   <= exec ? pc_next : pc_r;
    end
  end

  // checks; helpers recompute results from raw state so a broken alu cannot hide
  wire logic [7:0] chk_fval   = file_r[dec.faddr];
  wire logic       chk_bit    = chk_fval[dec.bidx];
  wire logic [8:0] chk_lsum   = {1'b0, acc_r} + {1'b0, dec.lit};
  wire logic [4:0] chk_nib    = {1'b0, acc_r[3:0]} + {1'b0, dec.lit[3:0]};
  wire logic [8:0] chk_fsum   = {1'b0, acc_r} + {1'b0, chk_fval};
  wire logic       chk_byteop = dec.op inside {CIE_ADD_ACC_FILE, CIE_AND_ACC_FILE, CIE_INV, CIE_DEC, CIE_DECSZ,
                                CIE_INC, CIE_INCSZ, CIE_ORWF, CIE_MOVE_FILE};

  a_skip_two_cycles: assert property (@(posedge clk_i) disable iff (rst_i)
    need_nop |=> go_r && q_r == 2'h0 && flush_r)
    else $error("skip did not add a no-op cycle");

  a_zero_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && alu.upd_z |=> status_r[ST_Z] == ($past(alu.res) == 8'h00))
    else $error("zero flag wrong");

  a_call_push: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op == CIE_CALL |=> sp_r == $past(sp_r) + 3'h1)
    else $error("call did not push");

  a_call_two: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op == CIE_CALL |=> flush_r && pc_r[JADDR_W-1:0] == $past(dec.jaddr))
    else $error("call target or second cycle wrong");

  a_jump_page: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && is_jump |=> pc_r[PC_W-1:PC_W-2] == $past(page_r[PAGE_LSB+1:PAGE_LSB]))
    else $error("jump page bits wrong");

  a_jump_no_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op == CIE_JMP |=> $stable(status_r) && $stable(sp_r) && flush_r)
    else $error("jump altered flags or stack");

  a_kick_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op == CIE_WDK |=> wdt_r == '0 && pre_r == '0 && status_r[ST_TO] && status_r[ST_PD])
    else $error("kick failed");

  a_nop_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op == CIE_IDLE |=> $stable(acc_r) && $stable(status_r) && pc_r == $past(pc_r) + 13'h0001)
    else $error("no-op changed state");

  a_flush_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    go_r && flush_r |-> !exec ##1 $stable(acc_r))
    else $error("squashed slot executed");

  a_cycle_len: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(go_r) && !wr_instr |-> ##3 last_q)
    else $error("instruction cycle not four clocks");

  a_skip_step: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && alu.skip |=> pc_r == $past(pc_r) + 13'h0002)
    else $error("skip did not step over next word");

  a_lit_add: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op == CIE_ADD_LITERAL_ACC |=> acc_r == $past(chk_lsum[7:0]))
    else $error("literal add result wrong");

  a_lit_carry: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op == CIE_ADD_LITERAL_ACC |=> status_r[ST_C] == $past(chk_lsum[8]) && status_r[ST_DC] == $past(chk_nib[4]))
    else $error("add carries wrong");

  a_file_add: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op == CIE_ADD_ACC_FILE && !dec.dest |=> acc_r == $past(chk_fsum[7:0]))
    else $error("file add result wrong");

  a_dest_acc: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && chk_byteop && !dec.dest |-> to_acc && !to_file)
    else $error("select 0 did not target accumulator");

  a_dest_file: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && chk_byteop && dec.dest |-> to_file && !to_acc)
    else $error("select 1 did not target file");

  a_and_lit: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op == CIE_AND_LITERAL_ACC |=> acc_r == ($past(acc_r) & $past(dec.lit)) && $stable(status_r[ST_DC:ST_C]))
    else $error("literal and wrong");

  a_and_file: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op == CIE_AND_ACC_FILE |-> alu.res == (acc_r & chk_fval) ##1 $stable(status_r[ST_DC:ST_C]))
    else $error("file and wrong");

  a_bit_set: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op == CIE_BSF |-> to_file && alu.res == (chk_fval | (8'h01 << dec.bidx)))
    else $error("bit set wrong");

  a_bit_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op == CIE_BCF |-> to_file && alu.res == (chk_fval & ~(8'h01 << dec.bidx)))
    else $error("bit clear wrong");

  a_bit_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op inside {CIE_BSF, CIE_BCF} |=> $stable(status_r))
    else $error("bit operation changed flags");

  a_skip_set: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op == CIE_BTSS |-> need_nop == chk_bit)
    else $error("skip on set wrong");

  a_skip_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op == CIE_BTSC |-> need_nop == !chk_bit)
    else $error("skip on clear wrong");

  a_zero_file: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op == CIE_ZF |-> to_file && alu.res == 8'h00 ##1 status_r[ST_Z])
    else $error("file clear wrong");

  a_zero_acc: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op == CIE_ZA |=> acc_r == 8'h00 && status_r[ST_Z])
    else $error("accumulator clear wrong");

  a_invert_file: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op == CIE_INV |-> alu.res == ~chk_fval)
    else $error("complement wrong");

  a_decrement_file: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op == CIE_DEC |-> alu.res == chk_fval - 8'h01)
    else $error("decrement wrong");

  a_dec_skip: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op == CIE_DECSZ |-> need_nop == (chk_fval == 8'h01) ##1 $stable(status_r))
    else $error("decrement skip wrong");

  a_inc_skip: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op == CIE_INCSZ |-> need_nop == (chk_fval == 8'hFF) ##1 $stable(status_r))
    else $error("increment skip wrong");

  a_increment_file: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op == CIE_INC |-> alu.res == chk_fval + 8'h01)
    else $error("increment wrong");

  a_or_lit: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op == CIE_ORLW |=> acc_r == ($past(acc_r) | $past(dec.lit)))
    else $error("literal or wrong");

  a_or_file: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op == CIE_ORWF |-> alu.res == (acc_r | chk_fval))
    else $error("file or wrong");

  a_move_file: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && dec.op == CIE_MOVE_FILE |-> alu.res == chk_fval && alu.upd_z)
    else $error("move wrong");
endmodule // cie_core

// ---- cie_pkg.sv ----
// shared constants and types for the core instruction execute block
package cie_pkg;
  // opcode field positions within the 14-bit instruction word, then counter, page, stack and watchdog sizes
  localparam int OP_W       = 14;
  localparam int FADDR_W    = 7;
  localparam int BIT_LSB    = 7;
  localparam int DEST_BIT   = 7;
  localparam int JADDR_W    = 11;
  localparam int PC_W       = 13;
  localparam int PAGE_LSB   = 3;
  localparam int STACK_D    = 8;
  localparam int STACK_AW   = 3;
  localparam int WDT_W      = 8;
  localparam int PRE_W      = 7;
  // one instruction cycle is four oscillator periods
  localparam int QUARTERS   = 4;

  // bus register offsets (byte addresses)
  localparam logic [7:0] REG_INSTR  = 8'h00;
  localparam logic [7:0] REG_ACC    = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_PC     = 8'h0C;
  localparam logic [7:0] REG_PAGE   = 8'h10;
  localparam logic [7:0] REG_HEAD   = 8'h14;
  localparam logic [7:0] REG_WDT    = 8'h18;
  localparam logic [7:0] REG_FADDR  = 8'h1C;
  localparam logic [7:0] REG_FDATA  = 8'h20;

  // status register bit positions
  localparam int ST_C  = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z  = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  localparam logic [7:0] STATUS_RST = 8'h18;

  typedef enum logic [4:0] {
    CIE_IDLE, CIE_ADD_LITERAL_ACC, CIE_ADD_ACC_FILE, CIE_AND_LITERAL_ACC, CIE_AND_ACC_FILE, CIE_BSF, CIE_BCF,
    CIE_BTSS, CIE_BTSC, CIE_CALL, CIE_JMP, CIE_WDK, CIE_ZF, CIE_ZA, CIE_INV,
    CIE_DEC, CIE_DECSZ, CIE_INC, CIE_INCSZ, CIE_ORLW, CIE_ORWF, CIE_MOVE_FILE, CIE_UNSUP
  } cie_op_t;

  // decoded instruction fields travel together
  typedef struct packed {
    cie_op_t             op;
    logic [FADDR_W-1:0]  faddr;
    logic                dest;
    logic [2:0]          bidx;
    logic [7:0]          lit;
    logic [JADDR_W-1:0]  jaddr;
  } cie_dec_t;

  // arithmetic result with flags
  typedef struct packed {
    logic [7:0] res;
    logic       c;
    logic       dc;
    logic       z;
    logic       upd_z;
    logic       upd_cdc;
    logic       skip;
  } cie_alu_t;
endpackage

// ---- cie_decode.sv ----
// instruction word decoder for the core execute block
`timescale 1ns/1ps
module cie_decode import cie_pkg::*; (
  input  wire logic [OP_W-1:0] instr_i,
  output cie_dec_t             dec_o
);
  wire logic [5:0] hi6 = instr_i[13:8];
  wire logic [3:0] hi4 = instr_i[13:10];
  wire logic [2:0] hi3 = instr_i[13:11];
  cie_op_t op;

  // opcode match; unsupported words fall to CIE_UNSUP and act as a no-op
  always_comb begin
    op = CIE_UNSUP;
    if (instr_i == 14'h0064) op = CIE_WDK;
    else if (instr_i[13:7] == 7'h00 && instr_i[4:0] == 5'h00) op = CIE_IDLE;
    else if (hi6 == 6'h07) op = CIE_ADD_ACC_FILE;
    else if (hi6 == 6'h05) op = CIE_AND_ACC_FILE;
    else if (hi6 == 6'h01) op = instr_i[DEST_BIT] ? CIE_ZF : CIE_ZA;
    else if (hi6 == 6'h09) op = CIE_INV;
    else if (hi6 == 6'h03) op = CIE_DEC;
    else if (hi6 == 6'h0B) op = CIE_DECSZ;
    else if (hi6 == 6'h0A) op = CIE_INC;
    else if (hi6 == 6'h0F) op = CIE_INCSZ;
    else if (hi6 == 6'h04) op = CIE_ORWF;
    else if (hi6 == 6'h08) op = CIE_MOVE_FILE;
    else if (hi4 == 4'h4) op = CIE_BCF;
    else if (hi4 == 4'h5) op = CIE_BSF;
    else if (hi4 == 4'h6) op = CIE_BTSC;
    else if (hi4 == 4'h7) op = CIE_BTSS;
    else if (hi3 == 3'h4) op = CIE_CALL;
    else if (hi3 == 3'h5) op = CIE_JMP;
    else if (instr_i[13:9] == 5'h1F) op = CIE_ADD_LITERAL_ACC;
    else if (hi6 == 6'h39) op = CIE_AND_LITERAL_ACC;
    else if (hi6 == 6'h38) op = CIE_ORLW;
  end

  // operand fields
  assign dec_o.op    = op;
  assign dec_o.faddr = instr_i[FADDR_W-1:0];
  assign dec_o.dest  = instr_i[DEST_BIT];
  assign dec_o.bidx  = instr_i[BIT_LSB+2:BIT_LSB];
  assign dec_o.lit   = instr_i[7:0];
  assign dec_o.jaddr = instr_i[JADDR_W-1:0];
endmodule // cie_decode

// ---- cie_alu.sv ----
// byte and literal arithmetic for the core execute block
`timescale 1ns/1ps
module cie_alu import cie_pkg::*; (
  input  wire cie_dec_t   dec_i,
  input  wire logic [7:0] acc_i,
  input  wire logic [7:0] file_i,
  output cie_alu_t        alu_o
);
  wire logic [7:0] opnd = (dec_i.op == CIE_ADD_LITERAL_ACC) ? dec_i.lit : file_i;
  wire logic [8:0] sum  = {1'b0, acc_i} + {1'b0, opnd};
  wire logic [4:0] nsum = {1'b0, acc_i[3:0]} + {1'b0, opnd[3:0]};
  wire logic [7:0] bmask = 8'h01 << dec_i.bidx;
  logic [7:0] r;

  // result select per operation
  always_comb begin
    r = file_i;
    case (dec_i.op)
      CIE_ADD_LITERAL_ACC, CIE_ADD_ACC_FILE: r = sum[7:0];
      CIE_AND_LITERAL_ACC:            r = acc_i & dec_i.lit;
      CIE_AND_ACC_FILE:            r = acc_i & file_i;
      CIE_BSF:              r = file_i | bmask;
      CIE_BCF:              r = file_i & ~bmask;
      CIE_ZF, CIE_ZA:       r = 8'h00;
      CIE_INV:              r = ~file_i;
      CIE_DEC, CIE_DECSZ:   r = file_i - 8'h01;
      CIE_INC, CIE_INCSZ:   r = file_i + 8'h01;
      CIE_ORLW:             r = acc_i | dec_i.lit;
      CIE_ORWF:             r = acc_i | file_i;
      CIE_MOVE_FILE:             r = file_i;
      default:              r = file_i;
    endcase
  end

  // flag and skip outputs
  assign alu_o.res     = r;
  assign alu_o.c       = sum[8];
  assign alu_o.dc      = nsum[4];
  assign alu_o.z       = (r == 8'h00);
  assign alu_o.upd_cdc = (dec_i.op == CIE_ADD_LITERAL_ACC) || (dec_i.op == CIE_ADD_ACC_FILE);
  assign alu_o.upd_z   = alu_o.upd_cdc || (dec_i.op inside {CIE_AND_LITERAL_ACC, CIE_AND_ACC_FILE, CIE_ZF, CIE_ZA, CIE_INV,
                         CIE_DEC, CIE_INC, CIE_ORLW, CIE_ORWF, CIE_MOVE_FILE});
  assign alu_o.skip    = ((dec_i.op == CIE_BTSS) && file_i[dec_i.bidx])
                       || ((dec_i.op == CIE_BTSC) && !file_i[dec_i.bidx])
                       || ((dec_i.op inside {CIE_DECSZ, CIE_INCSZ}) && (r == 8'h00));
endmodule // cie_alu

// ---- cie_core_bench.sv ----
// self-checking bench for the core instruction execute block
`timescale 1ns/1ps
module cie_core_bench import cie_pkg::*;;
  // one row per instruction: word, acc and file before, acc and file after, flags {z,dc,c}, flag mask, skip
  typedef struct packed {
    logic [13:0] ins;
    logic [7:0]  a;
    logic [7:0]  f;
    logic [7:0]  ea;
    logic [7:0]  ef;
    logic [2:0]  fl;
    logic [2:0]  m;
    logic        sk;
  } cie_vec_t;

  logic            clk_i = 1'h0;
  logic            rst_i = 1'h1;
  logic            cyc_i = 1'h0;
  logic            stb_i = 1'h0;
  logic            we_i  = 1'h0;
  logic [7:0]      adr_i = 8'h00;
  logic [3:0]      sel_i = 4'hF;
  logic [31:0]     dat_i = 32'h0;
  logic [31:0]     dat_o;
  logic            ack_o;
  logic            busy_o;
  logic [PC_W-1:0] pc_o;
  int              errors = 0;
  int              total_checks = 0;

  // flag-neutral rows sit after rows that leave the flags in a known non-reset state
  cie_vec_t tbl [0:25] = '{
    '{14'h07A0, 8'h0F, 8'h01, 8'h0F, 8'h10, 3'h2, 3'h7, 1'h0},
    '{14'h0720, 8'h80, 8'h80, 8'h00, 8'h80, 3'h5, 3'h7, 1'h0},
    '{14'h1FA0, 8'h00, 8'h80, 8'h00, 8'h80, 3'h0, 3'h0, 1'h1},
    '{14'h1FA0, 8'h00, 8'h7F, 8'h00, 8'h7F, 3'h0, 3'h0, 1'h0},
    '{14'h1820, 8'h00, 8'hFE, 8'h00, 8'hFE, 3'h0, 3'h0, 1'h1},
    '{14'h1820, 8'h00, 8'h01, 8'h00, 8'h01, 3'h0, 3'h0, 1'h0},
    '{14'h3E88, 8'h88, 8'h00, 8'h10, 8'h00, 3'h3, 3'h7, 1'h0},
    '{14'h0BA0, 8'h00, 8'h01, 8'h00, 8'h00, 3'h0, 3'h0, 1'h1},
    '{14'h0B20, 8'h00, 8'h03, 8'h02, 8'h03, 3'h0, 3'h0, 1'h0},
    '{14'h3FFF, 8'h01, 8'h00, 8'h00, 8'h00, 3'h7, 3'h7, 1'h0},
    '{14'h0FA0, 8'h00, 8'hFF, 8'h00, 8'h00, 3'h0, 3'h0, 1'h1},
    '{14'h0F20, 8'h00, 8'h10, 8'h11, 8'h10, 3'h0, 3'h0, 1'h0},
    '{14'h0520, 8'hF0, 8'h3C, 8'h30, 8'h3C, 3'h0, 3'h4, 1'h0},
    '{14'h390F, 8'hF0, 8'h3C, 8'h00, 8'h3C, 3'h4, 3'h4, 1'h0},
    '{14'h3881, 8'h02, 8'h3C, 8'h83, 8'h3C, 3'h0, 3'h4, 1'h0},
    '{14'h0100, 8'h55, 8'h55, 8'h00, 8'h55, 3'h4, 3'h4, 1'h0},
    '{14'h04A0, 8'h01, 8'h10, 8'h01, 8'h11, 3'h0, 3'h4, 1'h0},
    '{14'h01A0, 8'h00, 8'h55, 8'h00, 8'h00, 3'h4, 3'h4, 1'h0},
    '{14'h17A0, 8'h00, 8'h01, 8'h00, 8'h81, 3'h0, 3'h0, 1'h0},
    '{14'h1020, 8'h00, 8'h81, 8'h00, 8'h80, 3'h0, 3'h0, 1'h0},
    '{14'h0AA0, 8'h00, 8'hFE, 8'h00, 8'hFF, 3'h0, 3'h4, 1'h0},
    '{14'h09A0, 8'h00, 8'hFF, 8'h00, 8'h00, 3'h4, 3'h4, 1'h0},
    '{14'h0320, 8'h00, 8'h01, 8'h00, 8'h01, 3'h4, 3'h4, 1'h0},
    '{14'h0820, 8'h00, 8'h7E, 8'h7E, 8'h7E, 3'h0, 3'h4, 1'h0},
    '{14'h08A0, 8'h00, 8'h00, 8'h00, 8'h00, 3'h4, 3'h4, 1'h0},
    '{14'h0000, 8'h5A, 8'h5A, 8'h5A, 8'h5A, 3'h0, 3'h0, 1'h0}
  };

  cie_core #(.FILE_DEPTH(128)) cie_core_inst (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .cyc_i  (cyc_i),
    .stb_i  (stb_i),
    .we_i   (we_i),
    .adr_i  (adr_i),
    .sel_i  (sel_i),
    .dat_i  (dat_i),
    .dat_o  (dat_o),
    .ack_o  (ack_o),
    .busy_o (busy_o),
    .pc_o   (pc_o)
  );

  // 50 MHz core clock
  always #10 clk_i = ~clk_i;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // classic single cycle; the request stands until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i  <= we;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'h1 && n < 50);
    q = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    we_i  <= 1'h0;
    if (n >= 50) begin
      chk(32'h0, 32'h1);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'h0, a, 32'h0, q);
    chk(q, exp);
  endtask

  // counts busy cycles, bounded so a stuck busy cannot hang the run
  task automatic wait_idle(output int n);
    n = 0;
    while (busy_o === 1'h1 && n < 20) begin
      n++;
      @(posedge clk_i);
    end
  endtask

  task automatic run(input logic [13:0] ins, output int n);
    logic [31:0] q;
    wb(1'h1, REG_INSTR, {18'h0, ins}, q);
    wait_idle(n);
  endtask

  task automatic final_report();
    $display("checks made %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hang guard, far beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    final_report();
  end

  initial begin
    logic [31:0]     q;
    logic [31:0]     scratch;
    logic [PC_W-1:0] p0;
    logic [2:0]      st;
    int              n;
    cie_vec_t        t;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    // reset values, read-only status, unmapped space
    rd_chk(REG_STATUS, {24'h0, STATUS_RST});
    rd_chk(REG_ACC, 32'h0);
    wb(1'h1, REG_STATUS, 32'h0, q);
    rd_chk(REG_STATUS, {24'h0, STATUS_RST});
    wb(1'h1, 8'h3C, 32'hFF, q);
    rd_chk(8'h3C, 32'h0);
    $display("test reset done");
    // every byte, bit, literal and skip operation on file 0x20
    st = 3'h0;
    wb(1'h1, REG_FADDR, 32'h20, q);
    foreach (tbl[i]) begin
      t = tbl[i];
      wb(1'h1, REG_ACC, {24'h0, t.a}, q);
      wb(1'h1, REG_FDATA, {24'h0, t.f}, q);
      p0 = pc_o;
      run(t.ins, n);
      st = (st & ~t.m) | (t.fl & t.m);
      chk(32'(n), t.sk ? 32'h8 : 32'h4);
      rd_chk(REG_ACC, {24'h0, t.ea});
      rd_chk(REG_FDATA, {24'h0, t.ef});
      rd_chk(REG_STATUS, {27'h3, st});
      chk({19'h0, pc_o}, {19'h0, p0 + 13'(t.sk ? 2 : 1)});
    end
    $display("test table done");
    // watchdog has counted by now; a kick must bring it back to zero
    wb(1'h0, REG_WDT, 32'h0, q);
    chk(32'(q != 32'h0), 32'h1);
    run(14'h0064, n);
    rd_chk(REG_WDT, 32'h0);
    rd_chk(REG_STATUS, {27'h3, st});
    $display("test watchdog done");
    // jumps and calls take the top counter bits from the page latch
    wb(1'h1, REG_PAGE, 32'h10, q);
    run(14'h2805, n);
    chk(32'(n), 32'h8);
    rd_chk(REG_PC, 32'h1005);
    wb(1'h1, REG_PAGE, 32'h08, q);
    run(14'h2123, n);
    chk(32'(n), 32'h8);
    rd_chk(REG_PC, 32'h0923);
    rd_chk(REG_HEAD, 32'h1006);
    wb(1'h1, REG_PAGE, 32'h18, q);
    run(14'h2FFF, n);
    rd_chk(REG_PC, 32'h1FFF);
    rd_chk(REG_HEAD, 32'h1006);
    rd_chk(REG_STATUS, {27'h3, st});
    $display("test jumps done");
    // an accumulator write that lands while busy is dropped
    wb(1'h0, REG_ACC, 32'h0, q);
    p0 = pc_o;
    wb(1'h1, REG_INSTR, 32'h0, scratch);
    wb(1'h1, REG_ACC, 32'h77, scratch);
    wait_idle(n);
    rd_chk(REG_ACC, q);
    chk({19'h0, pc_o}, {19'h0, p0 + 13'h1});
    $display("test busy refusal done");
    final_report();
  end
endmodule // cie_core_bench
